// ==== rtl/an_np_params.svh ====
// Offsets, field positions and reset values of the next-page register group
`ifndef AN_NP_PARAMS_SVH
`define AN_NP_PARAMS_SVH

// Register offsets on the management register port
`define AN_EXPANSION_ADDR 5'h06
`define AN_NP_TX_ADDR 5'h07
`define AN_NP_RX_ADDR 5'h08

// Expansion register fields
`define EXP_BASE_PAGE_BIT 5
`define EXP_PAR_FAULT_BIT 4
`define EXP_PARTNER_NP_BIT 3
`define EXP_LOCAL_NP_BIT 2
`define EXP_PAGE_RX_BIT 1
`define EXP_PARTNER_AN_BIT 0
`define EXP_LOCAL_NP_VALUE 1'h1

// Link code word fields, shared by transmit and receive next pages
`define NP_MORE_PAGES_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_PAGE_BIT 13
`define NP_SECOND_ACKNOWLEDGE_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10
`define NP_CODE_LSB 0

// Reset values
`define NP_TX_RESET 16'h2001
`define NP_RX_RESET 16'h0000
`define WORD_ZERO 16'h0000

`endif

// ==== rtl/an_np_pkg.sv ====
// Types shared by the next-page register group
package an_np_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0] reg_addr_t;
endpackage

// ==== rtl/autoneg_next_page_regs.sv ====
// Auto-negotiation expansion, next-page transmit and next-page receive registers
//
// Contract
// - Latch base page status; only with alt feature
// - Parallel detection fault latches until read
// - Report partner next-page ability, read-only
// - Local next-page ability always reads one
// - Store received page, then flag page received
// - Expansion read clears page received afterwards
// - Alt feature: clear on no-rx or txdisable
// - Report partner auto-negotiation ability, read-only
// - Reserved transmit bit read-only, reads zero
// - Transmit toggle alternates on every sent page
// - Capture received continuation bit
// - Capture received acknowledge bit
// - Capture received page type bit
// - Capture received second acknowledge bit
// - Capture received toggle bit
`timescale 1ns/1ps
`default_nettype none
`include "an_np_params.svh"

module autoneg_next_page_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Management register port
  input wire an_np_pkg::reg_addr_t mgmt_addr_in,
  input wire logic mgmt_wr_in,
  input wire logic mgmt_rd_in,
  input wire an_np_pkg::word_t mgmt_wdata_in,
  output an_np_pkg::word_t mgmt_rdata_out,
  output logic mgmt_rdata_valid_out,
  // Configuration and line-side status from the arbitration logic
  input wire logic alt_page_feature_enable_in,
  input wire logic base_page_var_in,
  input wire logic parallel_fault_in,
  input wire logic partner_np_able_in,
  input wire logic partner_an_able_in,
  input wire logic mr_page_rx_in,
  input wire logic transmit_disable_in,
  // Received pages
  input wire logic page_rx_in,
  input wire logic page_is_next_in,
  input wire an_np_pkg::word_t page_word_in,
  output an_np_pkg::word_t base_page_word_out,
  // Transmitted next pages
  input wire logic tx_page_ack_in,
  output an_np_pkg::word_t tx_word_out,
  output logic tx_word_valid_out
);
  import an_np_pkg::*;

  // Transmit next-page fields; the reserved bit has no store
  logic tx_more_pages_follow;
  logic tx_page_type_message;
  logic tx_second_acknowledge;
  logic tx_toggle;
  logic [`NP_CODE_MSB:`NP_CODE_LSB] tx_code;
  word_t np_tx;

  // Receive next-page fields, written only by arriving pages
  logic rx_more_pages_follow;
  logic rx_ack;
  logic rx_page_type_message;
  logic rx_second_acknowledge;
  logic rx_toggle;
  logic [`NP_CODE_MSB:`NP_CODE_LSB] rx_code;
  word_t np_rx;

  // Expansion flags, decode strobes and the read mux
  logic base_page_seen;
  logic par_fault_seen;
  logic page_received;
  logic exp_read;
  logic np_tx_write;
  logic np_rx_page;
  logic base_rx_page;
  logic base_page_set;
  logic alt_clear;
  word_t exp_value;
  word_t next_rdata;

  // Reset images as words, so single fields can be picked out
  localparam word_t TX_RESET_WORD = `NP_TX_RESET;
  localparam word_t RX_RESET_WORD = `NP_RX_RESET;

  // Address match, used by both the read and the write decode
  function automatic logic hit(input reg_addr_t addr, input reg_addr_t target);
    hit = (addr == target);
  endfunction

  // Latching-high flag; a set in the clearing cycle is kept
  function automatic logic next_latch(input logic cur, input logic set, input logic clr);
    next_latch = set | (cur & ~clr);
  endfunction

  // Code field of a link code word, shared by both directions
  function automatic logic [`NP_CODE_MSB:`NP_CODE_LSB] code_field(input word_t w);
    code_field = w[`NP_CODE_MSB:`NP_CODE_LSB];
  endfunction

  // Strobe decode; writes to offsets 6 and 8 reach no store
  assign exp_read = mgmt_rd_in && hit(mgmt_addr_in, `AN_EXPANSION_ADDR);
  assign np_tx_write = mgmt_wr_in && hit(mgmt_addr_in, `AN_NP_TX_ADDR);

  // Page arrival split by page kind
  assign np_rx_page = page_rx_in && page_is_next_in;
  assign base_rx_page = page_rx_in && !page_is_next_in;

  // Alt feature gates both the base page latch and the extra clear
  assign base_page_set = alt_page_feature_enable_in && base_page_var_in;
  assign alt_clear = alt_page_feature_enable_in
    && (!mr_page_rx_in || transmit_disable_in);

  // Transmit register image as software reads it
  always_comb begin
    np_tx = `WORD_ZERO;
    np_tx[`NP_MORE_PAGES_BIT] = tx_more_pages_follow;
    // Reserved bit left at zero, whatever was written
    np_tx[`NP_MSG_PAGE_BIT] = tx_page_type_message;
    np_tx[`NP_SECOND_ACKNOWLEDGE_BIT] = tx_second_acknowledge;
    np_tx[`NP_TOGGLE_BIT] = tx_toggle;
    np_tx[`NP_CODE_MSB:`NP_CODE_LSB] = tx_code;
  end

  // Receive register image, fields as the partner sent them
  always_comb begin
    np_rx = `WORD_ZERO;
    np_rx[`NP_MORE_PAGES_BIT] = rx_more_pages_follow;
    np_rx[`NP_ACK_BIT] = rx_ack;
    np_rx[`NP_MSG_PAGE_BIT] = rx_page_type_message;
    np_rx[`NP_SECOND_ACKNOWLEDGE_BIT] = rx_second_acknowledge;
    np_rx[`NP_TOGGLE_BIT] = rx_toggle;
    np_rx[`NP_CODE_MSB:`NP_CODE_LSB] = rx_code;
  end

  // Expansion register image; reserved bits read zero
  // Partner ability bits pass through live, not latched
  always_comb begin
    exp_value = `WORD_ZERO;
    exp_value[`EXP_BASE_PAGE_BIT] = base_page_seen;
    exp_value[`EXP_PAR_FAULT_BIT] = par_fault_seen;
    exp_value[`EXP_PARTNER_NP_BIT] = partner_np_able_in;
    exp_value[`EXP_LOCAL_NP_BIT] = `EXP_LOCAL_NP_VALUE;
    exp_value[`EXP_PAGE_RX_BIT] = page_received;
    exp_value[`EXP_PARTNER_AN_BIT] = partner_an_able_in;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (mgmt_addr_in)
      `AN_EXPANSION_ADDR: next_rdata = exp_value;
      `AN_NP_TX_ADDR: next_rdata = np_tx;
      `AN_NP_RX_ADDR: next_rdata = np_rx;
      default: next_rdata = `WORD_ZERO;
    endcase
  end

  // Read data registered; the old flag values go out before the clear lands
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_rdata_out <= `WORD_ZERO;
    end else if (mgmt_rd_in) begin
      mgmt_rdata_out <= next_rdata;
    end
  end

  // Read valid pulse, one cycle behind the strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_rdata_valid_out <= 1'b0;
    end else begin
      mgmt_rdata_valid_out <= mgmt_rd_in;
    end
  end

  // Base page status; clears on an expansion read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_page_seen <= 1'b0;
    end else begin
      base_page_seen <= next_latch(base_page_seen, base_page_set, exp_read);
    end
  end

  // Fault latch: a new fault in the read cycle survives the clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_fault_seen <= 1'b0;
    end else begin
      par_fault_seen <= next_latch(par_fault_seen, parallel_fault_in, exp_read);
    end
  end

  // Page received flag; arrival wins over every clear source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_received <= 1'b0;
    end else begin
      page_received <= next_latch(page_received, page_rx_in,
        exp_read || alt_clear);
    end
  end

  // Transmit fields are plain stores; nothing here checks that software
  // keeps the continuation bit or the second acknowledge meaningful.
  // The toggle is the only field that hardware moves on its own, so a
  // write that lands with an acknowledge loses its toggle value.

  // Continuation bit, set by software until its last page
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_more_pages_follow <= TX_RESET_WORD[`NP_MORE_PAGES_BIT];
    end else if (np_tx_write) begin
      tx_more_pages_follow <= mgmt_wdata_in[`NP_MORE_PAGES_BIT];
    end
  end

  // Page type of the outgoing next page
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_page_type_message <= TX_RESET_WORD[`NP_MSG_PAGE_BIT];
    end else if (np_tx_write) begin
      tx_page_type_message <= mgmt_wdata_in[`NP_MSG_PAGE_BIT];
    end
  end

  // Second acknowledge, set by software when it can comply
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_second_acknowledge <= TX_RESET_WORD[`NP_SECOND_ACKNOWLEDGE_BIT];
    end else if (np_tx_write) begin
      tx_second_acknowledge <= mgmt_wdata_in[`NP_SECOND_ACKNOWLEDGE_BIT];
    end
  end

  // Toggle flips per sent page, even over a same-cycle write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_toggle <= TX_RESET_WORD[`NP_TOGGLE_BIT];
    end else if (tx_page_ack_in) begin
      tx_toggle <= ~tx_toggle;
    end else if (np_tx_write) begin
      tx_toggle <= mgmt_wdata_in[`NP_TOGGLE_BIT];
    end
  end

  // Message or unformatted code field of the outgoing page
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_code <= TX_RESET_WORD[`NP_CODE_MSB:`NP_CODE_LSB];
    end else if (np_tx_write) begin
      tx_code <= code_field(mgmt_wdata_in);
    end
  end

  // Partner continuation bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_more_pages_follow <= RX_RESET_WORD[`NP_MORE_PAGES_BIT];
    end else if (np_rx_page) begin
      rx_more_pages_follow <= page_word_in[`NP_MORE_PAGES_BIT];
    end
  end

  // Partner acknowledge of our code word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_ack <= RX_RESET_WORD[`NP_ACK_BIT];
    end else if (np_rx_page) begin
      rx_ack <= page_word_in[`NP_ACK_BIT];
    end
  end

  // Partner page type
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_page_type_message <= RX_RESET_WORD[`NP_MSG_PAGE_BIT];
    end else if (np_rx_page) begin
      rx_page_type_message <= page_word_in[`NP_MSG_PAGE_BIT];
    end
  end

  // Partner second acknowledge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_second_acknowledge <= RX_RESET_WORD[`NP_SECOND_ACKNOWLEDGE_BIT];
    end else if (np_rx_page) begin
      rx_second_acknowledge <= page_word_in[`NP_SECOND_ACKNOWLEDGE_BIT];
    end
  end

  // Partner toggle, kept as received
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_toggle <= RX_RESET_WORD[`NP_TOGGLE_BIT];
    end else if (np_rx_page) begin
      rx_toggle <= page_word_in[`NP_TOGGLE_BIT];
    end
  end

  // Partner code field
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_code <= RX_RESET_WORD[`NP_CODE_MSB:`NP_CODE_LSB];
    end else if (np_rx_page) begin
      rx_code <= code_field(page_word_in);
    end
  end

  // Base page store for the partner ability register outside this block
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_page_word_out <= `WORD_ZERO;
    end else if (base_rx_page) begin
      base_page_word_out <= page_word_in;
    end
  end

  // Next link code word issued once the previous one is acknowledged
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_word_out <= `WORD_ZERO;
    end else if (tx_page_ack_in) begin
      tx_word_out <= np_tx;
    end
  end

  // Word valid pulse; the word itself holds until the next acknowledge
  // so a slow consumer may still pick it up later
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_word_valid_out <= 1'b0;
    end else begin
      tx_word_valid_out <= tx_page_ack_in;
    end
  end

endmodule

`default_nettype wire

// ==== bench/autoneg_next_page_regs_asserts.sv ====
// Port assertions for the next-page register group
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs_asserts (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire an_np_pkg::reg_addr_t mgmt_addr_in,
  input wire logic mgmt_rd_in,
  input wire an_np_pkg::word_t mgmt_rdata_out,
  input wire logic alt_page_feature_enable_in,
  input wire logic mr_page_rx_in,
  input wire logic parallel_fault_in,
  input wire logic page_rx_in,
  input wire logic page_is_next_in,
  input wire an_np_pkg::word_t page_word_in,
  input wire an_np_pkg::word_t base_page_word_out,
  input wire logic tx_page_ack_in,
  input wire an_np_pkg::word_t tx_word_out,
  input wire logic tx_word_valid_out
);
  import an_np_pkg::*;
  logic rd6;
  logic alt;
  // Status reads with no page landing, since a set beats the read clear
  assign rd6 = mgmt_rd_in && mgmt_addr_in == 5'h06 && !page_rx_in;
  assign alt = alt_page_feature_enable_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_np; rd6 |=> mgmt_rdata_out[2]; endproperty
  a_np: assert property (p_np) else $error("np");
  property p_flag; page_rx_in && !alt ##1 rd6 && !alt |=> mgmt_rdata_out[1]; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_clr; rd6 ##1 !page_rx_in ##1 rd6 |=> !mgmt_rdata_out[1]; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_fault; parallel_fault_in ##1 rd6 |=> mgmt_rdata_out[4]; endproperty
  a_fault: assert property (p_fault) else $error("fault");
  property p_alt; alt && !mr_page_rx_in && !page_rx_in ##1 rd6 |=> !mgmt_rdata_out[1]; endproperty
  a_alt: assert property (p_alt) else $error("alt");
  property p_base; page_rx_in && !page_is_next_in |=> base_page_word_out == $past(page_word_in);
  endproperty
  a_base: assert property (p_base) else $error("base");
  property p_tx; tx_page_ack_in |=> tx_word_valid_out && !tx_word_out[14]; endproperty
  a_tx: assert property (p_tx) else $error("tx");
  property p_tog; tx_page_ack_in [*2] |=> tx_word_out[11] != $past(tx_word_out[11]); endproperty
  a_tog: assert property (p_tog) else $error("tog");
endmodule
`default_nettype wire

// ==== bench/partner_station.sv ====
// Line-side link partner: page strobes and acknowledges
`timescale 1ns/1ps
`default_nettype none
module partner_station (
  input wire logic clk_in,
  output logic rx_out,
  output logic next_out,
  output an_np_pkg::word_t word_out,
  output logic ack_out
);
  import an_np_pkg::*;
  // Idle lines at time zero
  initial begin
    rx_out = 1'b0;
    next_out = 1'b0;
    word_out = 16'h0000;
    ack_out = 1'b0;
  end
  // One page for one cycle; stale word is garbled, not held
  task automatic send(input word_t w, input logic nxt);
    rx_out = 1'b1;
    next_out = nxt;
    word_out = w;
    @(posedge clk_in) #1;
    rx_out = 1'b0;
    word_out = ~w;
  endtask
  // Acknowledges held for n back-to-back cycles
  task automatic ack(input int n);
    ack_out = 1'b1;
    repeat (n) @(posedge clk_in);
    #1 ack_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== bench/autoneg_next_page_regs_tb_top.sv ====
// Self-checking bench for the next-page register group
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs_tb_top;
  import an_np_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mgmt_wr_in = 1'b0;
  logic mgmt_rd_in = 1'b0;
  reg_addr_t mgmt_addr_in = 5'h00;
  word_t mgmt_wdata_in = 16'h0000;
  logic alt_page_feature_enable_in = 1'b0;
  logic base_page_var_in = 1'b0;
  logic parallel_fault_in = 1'b0;
  logic partner_np_able_in = 1'b0;
  logic partner_an_able_in = 1'b0;
  logic mr_page_rx_in = 1'b1;
  logic transmit_disable_in = 1'b0;
  logic page_rx_in, page_is_next_in, tx_page_ack_in, mgmt_rdata_valid_out, tx_word_valid_out;
  word_t page_word_in, mgmt_rdata_out, base_page_word_out, tx_word_out;
  int n_fail = 0;
  int comparisons = 0;
  // 20 MHz clock
  always #25 clk_in = ~clk_in;
  autoneg_next_page_regs dut_u (.*);
  partner_station partner_u (.clk_in(clk_in), .rx_out(page_rx_in), .next_out(page_is_next_in),
    .word_out(page_word_in), .ack_out(tx_page_ack_in));
  task automatic cmp(input word_t got, input word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Strobe one access; a read without valid never matches
  task automatic acc(input logic wr, input reg_addr_t a, input word_t d);
    mgmt_wr_in = wr;
    mgmt_rd_in = !wr;
    mgmt_addr_in = a;
    mgmt_wdata_in = d;
    @(posedge clk_in) #1;
    mgmt_wr_in = 1'b0;
    mgmt_rd_in = 1'b0;
    if (!wr) cmp(mgmt_rdata_valid_out ? mgmt_rdata_out : 16'hxxxx, d);
    @(posedge clk_in) #1;
  endtask
  task automatic t_regs;
    acc(0, 5'h06, 16'h0004);
    acc(0, 5'h07, 16'h2001);
    acc(1, 5'h07, 16'hffff);
    acc(0, 5'h07, 16'hbfff);
    acc(1, 5'h08, 16'hffff);
    acc(1, 5'h06, 16'hffff);
    acc(1, 5'h1f, 16'hffff);
    acc(0, 5'h08, 16'h0000);
    acc(0, 5'h06, 16'h0004);
    acc(0, 5'h1f, 16'h0000);
  endtask
  task automatic t_rx;
    partner_u.send(16'hd9a5, 1'b1);
    acc(0, 5'h06, 16'h0006);
    acc(0, 5'h06, 16'h0004);
    acc(0, 5'h08, 16'hd9a5);
    partner_u.send(16'h2345, 1'b0);
    cmp(base_page_word_out, 16'h2345);
    acc(0, 5'h06, 16'h0006);
  endtask
  task automatic t_flags;
    partner_np_able_in = 1'b1;
    partner_an_able_in = 1'b1;
    parallel_fault_in = 1'b1;
    @(posedge clk_in) #1;
    parallel_fault_in = 1'b0;
    acc(0, 5'h06, 16'h001d);
    acc(0, 5'h06, 16'h000d);
    alt_page_feature_enable_in = 1'b1;
    base_page_var_in = 1'b1;
    partner_u.send(16'h0000, 1'b1);
    mr_page_rx_in = 1'b0;
    @(posedge clk_in) #1;
    base_page_var_in = 1'b0;
    acc(0, 5'h06, 16'h002d);
    acc(0, 5'h06, 16'h000d);
    alt_page_feature_enable_in = 1'b0;
    mr_page_rx_in = 1'b1;
  endtask
  // Alt feature off ignores both; on, transmit disable clears the flag
  task automatic t_alt;
    base_page_var_in = 1'b1;
    mr_page_rx_in = 1'b0;
    partner_u.send(16'h0000, 1'b1);
    base_page_var_in = 1'b0;
    acc(0, 5'h06, 16'h000f);
    mr_page_rx_in = 1'b1;
    transmit_disable_in = 1'b1;
    alt_page_feature_enable_in = 1'b1;
    partner_u.send(16'h0000, 1'b1);
    @(posedge clk_in) #1;
    acc(0, 5'h06, 16'h000d);
    transmit_disable_in = 1'b0;
    alt_page_feature_enable_in = 1'b0;
  endtask
  task automatic t_tx;
    acc(1, 5'h07, 16'h9a55);
    partner_u.ack(2);
    cmp(tx_word_valid_out ? tx_word_out : 16'hxxxx, 16'h9255);
    acc(0, 5'h07, 16'h9a55);
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    t_regs();
    t_rx();
    t_flags();
    t_alt();
    t_tx();
    complete_run();
  end
  // Watchdog at about three times the expected run
  initial begin
    #10000;
    n_fail++;
    complete_run();
  end
endmodule
bind autoneg_next_page_regs autoneg_next_page_regs_asserts chk_u (.*);
`default_nettype wire
